//--- pkg/lhr_pkg.sv
// Overview of operation
// (RL1) Stop interval code 0..6 selects 8192 up to 67108864 pulses.
// (RL2) Incremental scale: references every interval from first mark after start.
// (RL3) Dog return, incremental: after dog trailing edge, nearest reference plus shift.
// (RL4) Multipoint option on: marks accepted from more than one location.
// (RL5) Absolute scale: references at whole interval multiples from position zero.
// (RL6) Dog return, absolute: first reference reached after dog off is home. Here shift A plus B is added to it in this mode too.
// (RL7) Index pulse marks reference positions of the selected interval.
// (RL8) Absolute scale: data set return takes current position as home.
// (RL9) Return with no mark ahead flags an error; controller pre-positions axis.
// (RL10) Codes above 6 are refused; previous valid interval is kept. Here any word above 6 is flagged, but bits 2:0 are taken unless they are 7.
package lhr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] LHR_CTRL_ADDR = 12'h000;
    localparam logic [11:0] LHR_SEL_ADDR = 12'h004;
    localparam logic [11:0] LHR_SHA_ADDR = 12'h008;
    localparam logic [11:0] LHR_SHB_ADDR = 12'h00c;
    localparam logic [11:0] LHR_STS_ADDR = 12'h010;
    localparam logic [11:0] LHR_MASK_ADDR = 12'h014;
    localparam logic [11:0] LHR_STATE_ADDR = 12'h018;
    localparam logic [11:0] LHR_HOME_ADDR = 12'h01c;
    // CTRL fields
    localparam int LHR_CTRL_ABS = 0;
    localparam int LHR_CTRL_DSET = 1;
    localparam int LHR_CTRL_MULTI = 2;
    localparam int LHR_CTRL_START = 3;
    // Status / mask bits
    localparam int LHR_STS_W = 4;
    localparam int LHR_STS_DONE = 0;
    localparam int LHR_STS_ERR = 1;
    localparam int LHR_STS_INDEX = 2;
    localparam int LHR_STS_BADSEL = 3;
    // Reset values and largest legal interval code
    localparam logic [2:0] LHR_SEL_RST = 3'h3;
    localparam logic [2:0] LHR_SEL_MAX = 3'h6;
    localparam logic [31:0] LHR_SHIFT_RST = 32'h0;
    localparam logic [3:0] LHR_MASK_RST = 4'h0;
    // Interval exponents for codes 0..6 and minimum position width
    localparam logic [4:0] LHR_EXP0 = 5'h0d;
    localparam logic [4:0] LHR_EXP1 = 5'h11;
    localparam logic [4:0] LHR_EXP2 = 5'h12;
    localparam logic [4:0] LHR_EXP3 = 5'h14;
    localparam logic [4:0] LHR_EXP4 = 5'h16;
    localparam logic [4:0] LHR_EXP5 = 5'h18;
    localparam logic [4:0] LHR_EXP6 = 5'h1a;
    localparam int LHR_POS_MIN_W = 27;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DOG_ON,
        ST_DOG_OFF,
        ST_REF
    } lhr_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lhr_apb_req_t;

    typedef struct packed {
        logic [31:0] position;
        logic mark;
        logic dog;
    } lhr_enc_t;
endpackage

//--- rtl/lhr_gen.sv
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ns
module lhr_gen #(
    parameter int POS_W = 32
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    input wire lhr_pkg::lhr_apb_req_t APB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire lhr_pkg::lhr_enc_t ENC_I,
    input wire logic START_I,
    output logic INDEX_PULSE_O,
    output logic HOME_VALID_O,
    output logic [31:0] HOME_POS_O,
    output logic BUSY_O,
    output logic IRQ_O
);
    // ****************************************
    // Types and helpers
    // ****************************************
    typedef logic [POS_W-1:0] lhr_pos_t;

    typedef struct packed {
        logic ctrl_abs;
        logic ctrl_dset;
        logic multipoint_mark_select;
        logic [2:0] stop_interval_select;
        logic [31:0] home_shift_distance_a;
        logic [31:0] home_shift_distance_b;
        logic [lhr_pkg::LHR_STS_W-1:0] sts;
        logic [lhr_pkg::LHR_STS_W-1:0] mask;
        lhr_pkg::lhr_state_t st;
        lhr_pos_t base;
        logic base_ok;
        lhr_pos_t anchor;
        logic anchor_ok;
        lhr_pos_t idx;
        logic mark_prev;
        logic dog_prev;
        lhr_pos_t home;
        logic home_ok;
        logic index_pulse_out;
    } lhr_regs_t;

    function automatic logic [4:0] interval_exp(input logic [2:0] code);
        logic [4:0] e;
        unique case (code)
            3'h0: e = lhr_pkg::LHR_EXP0;
            3'h1: e = lhr_pkg::LHR_EXP1;
            3'h2: e = lhr_pkg::LHR_EXP2;
            3'h3: e = lhr_pkg::LHR_EXP3;
            3'h4: e = lhr_pkg::LHR_EXP4;
            3'h5: e = lhr_pkg::LHR_EXP5;
            default: e = lhr_pkg::LHR_EXP6;
        endcase
        return e;
    endfunction

    function automatic lhr_pos_t ref_index(input lhr_pos_t pos,
        input lhr_pos_t org, input logic [4:0] e);
        return (pos - org) >> e;
    endfunction

    initial
    begin
        if (POS_W < lhr_pkg::LHR_POS_MIN_W || POS_W > 32)
        begin
            $error("POS_W must lie between 27 and 32");
        end
    end

    lhr_regs_t r_ff;
    lhr_regs_t nxt_r;

    logic wr_en;
    logic rd_hit;
    logic [31:0] rd_data;
    lhr_pos_t pos;
    lhr_pos_t org;
    lhr_pos_t cur_idx;
    lhr_pos_t ref_pos;
    logic ref_ok;
    logic crossed;
    logic mark_rise;
    logic dog_fall;
    logic start;
    logic ctrl_wr;
    logic mode_abs;
    logic mode_dset;
    logic [4:0] exp_sel;
    logic [31:0] shift_sum;
    logic [lhr_pkg::LHR_STS_W-1:0] ev;

    // ****************************************
    // APB slave, zero wait states
    // ****************************************
    assign wr_en = APB_I.psel && APB_I.penable && APB_I.pwrite && CE_I;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = APB_I.psel && APB_I.penable && !rd_hit;

    always_comb
    begin
        rd_hit = 1'b1;
        rd_data = 32'h0;
        unique case (APB_I.paddr)
            lhr_pkg::LHR_CTRL_ADDR:
                rd_data = {29'h0, r_ff.multipoint_mark_select,
                    r_ff.ctrl_dset, r_ff.ctrl_abs};
            lhr_pkg::LHR_SEL_ADDR:
                rd_data = {29'h0, r_ff.stop_interval_select};
            lhr_pkg::LHR_SHA_ADDR: rd_data = r_ff.home_shift_distance_a;
            lhr_pkg::LHR_SHB_ADDR: rd_data = r_ff.home_shift_distance_b;
            lhr_pkg::LHR_STS_ADDR: rd_data = 32'(r_ff.sts);
            lhr_pkg::LHR_MASK_ADDR: rd_data = 32'(r_ff.mask);
            lhr_pkg::LHR_STATE_ADDR:
                rd_data = {27'h0, r_ff.home_ok, r_ff.base_ok,
                    3'(r_ff.st)};
            lhr_pkg::LHR_HOME_ADDR: rd_data = 32'(r_ff.home);
            default: rd_hit = 1'b0;
        endcase
    end
    assign PRDATA_O = rd_data;

    // ****************************************
    // Reference grid
    // ****************************************
    assign pos = lhr_pos_t'(ENC_I.position);
    assign exp_sel = interval_exp(r_ff.stop_interval_select); // see (RL1)
    // Absolute grid is anchored at zero, incremental at the latched mark
    assign org = r_ff.ctrl_abs ? '0 : r_ff.base; // see (RL5) see (RL2)
    assign ref_ok = r_ff.ctrl_abs || r_ff.base_ok;
    assign cur_idx = ref_index(pos, org, exp_sel);
    // Crossing seen as a change of grid cell, in either direction
    assign crossed = ref_ok && (cur_idx != r_ff.idx); // see (RL7)
    assign ref_pos = (((cur_idx > r_ff.idx) ? cur_idx : r_ff.idx)
        << exp_sel) + org;
    assign shift_sum = r_ff.home_shift_distance_a
        + r_ff.home_shift_distance_b;
    assign mark_rise = ENC_I.mark && !r_ff.mark_prev;
    assign dog_fall = !ENC_I.dog && r_ff.dog_prev;
    assign ctrl_wr = wr_en && APB_I.paddr == lhr_pkg::LHR_CTRL_ADDR;
    assign start = START_I
        || (ctrl_wr && APB_I.pwdata[lhr_pkg::LHR_CTRL_START]);
    // Start by a CTRL write runs in the mode written with it
    assign mode_abs = ctrl_wr ? APB_I.pwdata[lhr_pkg::LHR_CTRL_ABS]
        : r_ff.ctrl_abs;
    assign mode_dset = ctrl_wr ? APB_I.pwdata[lhr_pkg::LHR_CTRL_DSET]
        : r_ff.ctrl_dset;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        nxt_r = r_ff;
        ev = '0;
        nxt_r.index_pulse_out = crossed;
        nxt_r.idx = cur_idx;
        nxt_r.mark_prev = ENC_I.mark;
        nxt_r.dog_prev = ENC_I.dog;
        ev[lhr_pkg::LHR_STS_INDEX] = crossed;

        if (wr_en)
        begin
            unique case (APB_I.paddr)
                lhr_pkg::LHR_CTRL_ADDR:
                begin
                    nxt_r.ctrl_abs = APB_I.pwdata[lhr_pkg::LHR_CTRL_ABS];
                    nxt_r.ctrl_dset = APB_I.pwdata[lhr_pkg::LHR_CTRL_DSET];
                    nxt_r.multipoint_mark_select =
                        APB_I.pwdata[lhr_pkg::LHR_CTRL_MULTI];
                end
                lhr_pkg::LHR_SEL_ADDR:
                begin
                    if (APB_I.pwdata[2:0] <= lhr_pkg::LHR_SEL_MAX)
                    begin
                        nxt_r.stop_interval_select = APB_I.pwdata[2:0];
                    end
                    if (APB_I.pwdata[31:0] > 32'(lhr_pkg::LHR_SEL_MAX))
                    begin
                        ev[lhr_pkg::LHR_STS_BADSEL] = 1'b1; // see (RL10)
                    end
                end
                lhr_pkg::LHR_SHA_ADDR:
                    nxt_r.home_shift_distance_a = APB_I.pwdata;
                lhr_pkg::LHR_SHB_ADDR:
                    nxt_r.home_shift_distance_b = APB_I.pwdata;
                lhr_pkg::LHR_STS_ADDR:
                    nxt_r.sts = r_ff.sts
                        & ~APB_I.pwdata[lhr_pkg::LHR_STS_W-1:0];
                lhr_pkg::LHR_MASK_ADDR:
                    nxt_r.mask = APB_I.pwdata[lhr_pkg::LHR_STS_W-1:0];
                default:
                begin
                end
            endcase
        end

        // Marks: single location unless the multipoint option is set
        if (mark_rise && !r_ff.ctrl_abs && r_ff.st != lhr_pkg::ST_IDLE
            && !r_ff.base_ok)
        begin
            if (r_ff.multipoint_mark_select || !r_ff.anchor_ok
                || r_ff.anchor == pos) // see (RL4)
            begin
                nxt_r.base = pos; // see (RL2)
                nxt_r.base_ok = 1'b1;
                nxt_r.anchor = pos;
                nxt_r.anchor_ok = 1'b1;
                nxt_r.idx = '0;
                nxt_r.index_pulse_out = 1'b0;
                ev[lhr_pkg::LHR_STS_INDEX] = 1'b0;
            end
        end

        unique case (r_ff.st)
            lhr_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    nxt_r.home_ok = 1'b0;
                    if (mode_dset)
                    begin
                        if (mode_abs)
                        begin
                            nxt_r.home = pos; // see (RL8)
                            nxt_r.home_ok = 1'b1;
                            ev[lhr_pkg::LHR_STS_DONE] = 1'b1;
                        end
                        else
                        begin
                            ev[lhr_pkg::LHR_STS_ERR] = 1'b1;
                        end
                    end
                    else
                    begin
                        nxt_r.base_ok = 1'b0;
                        nxt_r.st = ENC_I.dog ? lhr_pkg::ST_DOG_OFF
                            : lhr_pkg::ST_DOG_ON;
                    end
                end
            end
            lhr_pkg::ST_DOG_ON:
            begin
                if (ENC_I.dog)
                begin
                    nxt_r.st = lhr_pkg::ST_DOG_OFF;
                end
            end
            lhr_pkg::ST_DOG_OFF:
            begin
                if (dog_fall)
                begin
                    // No mark passed by dog end: no grid to stop on
                    if (ref_ok)
                    begin
                        nxt_r.st = lhr_pkg::ST_REF; // see (RL3) see (RL6)
                    end
                    else
                    begin
                        nxt_r.st = lhr_pkg::ST_IDLE;
                        ev[lhr_pkg::LHR_STS_ERR] = 1'b1; // see (RL9)
                    end
                end
            end
            lhr_pkg::ST_REF:
            begin
                if (crossed)
                begin
                    nxt_r.home = ref_pos + lhr_pos_t'(shift_sum); // see (RL3)
                    nxt_r.home_ok = 1'b1;
                    nxt_r.st = lhr_pkg::ST_IDLE;
                    ev[lhr_pkg::LHR_STS_DONE] = 1'b1;
                end
            end
            default: nxt_r.st = lhr_pkg::ST_IDLE;
        endcase
        // Set beats clear in the same cycle
        nxt_r.sts = nxt_r.sts | ev;
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            r_ff <= '0;
            r_ff.stop_interval_select <= lhr_pkg::LHR_SEL_RST;
            r_ff.home_shift_distance_a <= lhr_pkg::LHR_SHIFT_RST;
            r_ff.home_shift_distance_b <= lhr_pkg::LHR_SHIFT_RST;
            r_ff.mask <= lhr_pkg::LHR_MASK_RST;
            r_ff.st <= lhr_pkg::ST_IDLE;
        end
        else if (CE_I)
        begin
            r_ff <= nxt_r;
        end
    end

    assign INDEX_PULSE_O = r_ff.index_pulse_out;
    assign HOME_VALID_O = r_ff.home_ok;
    assign HOME_POS_O = 32'(r_ff.home);
    assign BUSY_O = r_ff.st != lhr_pkg::ST_IDLE;
    assign IRQ_O = |(r_ff.sts & r_ff.mask);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I || !CE_I);

    property p_sel_legal;
        r_ff.stop_interval_select <= lhr_pkg::LHR_SEL_MAX;
    endproperty
    a_sel_legal: assert property (p_sel_legal) // see (RL1)
        else $error("stop interval code out of range");

    property p_sel_keep;
        wr_en && APB_I.paddr == lhr_pkg::LHR_SEL_ADDR
            && APB_I.pwdata[2:0] == 3'h7
            |=> $stable(r_ff.stop_interval_select) && r_ff.sts[3];
    endproperty
    a_sel_keep: assert property (p_sel_keep) // see (RL10)
        else $error("illegal code changed the interval");

    property p_exp_map;
        r_ff.stop_interval_select == 3'h3 |-> exp_sel == 5'h14;
    endproperty
    a_exp_map: assert property (p_exp_map) // see (RL1)
        else $error("code 3 not decoded to 1048576");

    property p_index_cause;
        INDEX_PULSE_O |-> $past(ref_ok) && $past(cur_idx) != $past(r_ff.idx);
    endproperty
    a_index_cause: assert property (p_index_cause) // see (RL7)
        else $error("index pulse without a reference crossing");

    property p_abs_grid;
        r_ff.ctrl_abs && r_ff.stop_interval_select == 3'h0
            |-> cur_idx == (pos >> 13);
    endproperty
    a_abs_grid: assert property (p_abs_grid) // see (RL5)
        else $error("absolute grid not anchored at zero");

    property p_base_latch;
        !r_ff.base_ok ##1 r_ff.base_ok && !r_ff.ctrl_abs
            |-> r_ff.base == $past(pos) && $past(mark_rise);
    endproperty
    a_base_latch: assert property (p_base_latch) // see (RL2)
        else $error("incremental origin not taken at a mark");

    property p_single_point;
        !r_ff.multipoint_mark_select && r_ff.anchor_ok
            |=> r_ff.anchor == $past(r_ff.anchor);
    endproperty
    a_single_point: assert property (p_single_point) // see (RL4)
        else $error("second mark location accepted");

    property p_home_after_dog;
        r_ff.st == lhr_pkg::ST_REF && crossed
            |=> HOME_VALID_O && !BUSY_O
            && HOME_POS_O == 32'($past(ref_pos) + lhr_pos_t'($past(shift_sum)));
    endproperty
    a_home_after_dog: assert property (p_home_after_dog) // see (RL3)
        else $error("home not set to shifted reference");

    property p_ref_only_after_dog;
        r_ff.st == lhr_pkg::ST_REF |-> $past(r_ff.st) == lhr_pkg::ST_REF
            || ($past(r_ff.st) == lhr_pkg::ST_DOG_OFF && $past(dog_fall));
    endproperty
    a_ref_only_after_dog: assert property (p_ref_only_after_dog) // see (RL6)
        else $error("reference search began before dog off");

    property p_dset;
        r_ff.st == lhr_pkg::ST_IDLE && start && mode_dset
            && mode_abs |=> HOME_VALID_O && HOME_POS_O == 32'($past(pos));
    endproperty
    a_dset: assert property (p_dset) // see (RL8)
        else $error("data set return did not take position");

    property p_no_mark_err;
        r_ff.st == lhr_pkg::ST_DOG_OFF && dog_fall && !ref_ok
            |=> r_ff.sts[1] && !BUSY_O;
    endproperty
    a_no_mark_err: assert property (p_no_mark_err) // see (RL9)
        else $error("missing mark not flagged");

    c_dog_home: cover property (r_ff.st == lhr_pkg::ST_REF ##[1:1000] HOME_VALID_O);
    c_dset: cover property (start && mode_dset && mode_abs);
    c_err: cover property (r_ff.st == lhr_pkg::ST_DOG_OFF && dog_fall && !ref_ok);
endmodule

//--- tb/lhr_enc_model.sv
`timescale 1ns/1ns
module lhr_enc_model (
    input wire logic clk_i,
    output lhr_pkg::lhr_enc_t enc_o
);
    // ****************************************
    // Scale head and proximity dog
    // ****************************************
    initial enc_o = '0;

    // Hold lets the axis dwell, so slow moves are covered too
    task automatic drive(input logic [31:0] pos, input logic dog,
                         input int hold);
        @(posedge clk_i);
        enc_o.position <= pos;
        enc_o.dog <= dog;
        repeat (hold) @(posedge clk_i);
    endtask

    // Marks may sit at any place along the stroke
    task automatic mark();
        @(posedge clk_i);
        enc_o.mark <= 1'b1;
        @(posedge clk_i);
        enc_o.mark <= 1'b0;
    endtask
endmodule

//--- tb/lhr_gen_test.sv
`timescale 1ns/1ns
module lhr_gen_test;
    logic clk;
    logic srst;
    logic ce;
    lhr_pkg::lhr_apb_req_t apb;
    lhr_pkg::lhr_enc_t enc;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic start;
    logic idx;
    logic hv;
    logic [31:0] hpos;
    logic busy;
    logic irq;
    int err_total;
    int comparisons;
    int k;
    logic [31:0] rd;
    logic serr;
    logic [31:0] p;
    logic [31:0] m;
    logic [31:0] sh;
    logic [31:0] iv_q[$] = '{32'h2000, 32'h20000, 32'h40000, 32'h100000,
        32'h400000, 32'h1000000, 32'h4000000};

    lhr_gen lhr_gen_i (.CLK_I(clk), .SRST_I(srst), .CE_I(ce),
        .APB_I(apb), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .ENC_I(enc), .START_I(start),
        .INDEX_PULSE_O(idx), .HOME_VALID_O(hv), .HOME_POS_O(hpos),
        .BUSY_O(busy), .IRQ_O(irq));
    lhr_enc_model lhr_enc_model_i (.clk_i(clk), .enc_o(enc));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Idle cycle at the end keeps two calls from driving apb at one edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_total++;
            test_done();
        end
        rd = prdata;
        serr = pslverr;
        apb <= '0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic irq_is(input logic e);
        int n;
        for (n = 0; n < 8 && irq !== e; n++)
            @(posedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic go();
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask

    // Kind 0 failed, 1 data set, 2 grid crossing
    task automatic run(input logic [31:0] e, input int kind);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (busy === 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_total++;
            test_done();
        end
        chk({31'h0, hv}, {31'h0, kind != 0});
        if (kind != 0)
            chk(hpos, e);
        if (kind == 2)
            chk({31'h0, idx}, 32'h1);
    endtask

    // Axis starts short of the mark so one always lies ahead
    task automatic inc_ret(input logic [31:0] m, input logic ok);
        logic [31:0] t;
        t = iv_q[0] * $urandom_range(3, 1);
        lhr_enc_model_i.drive(m - 32'h5, 1'b0, 1);
        go();
        lhr_enc_model_i.drive(m - 32'h5, 1'b1, 2);
        lhr_enc_model_i.drive(m, 1'b1, 0);
        lhr_enc_model_i.mark();
        lhr_enc_model_i.drive(m + 32'h1, 1'b0, 2);
        if (ok)
            lhr_enc_model_i.drive(m + t + 32'h1, 1'b0, 0);
        run(m + t + sh, ok ? 2 : 0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        err_total = 0;
        comparisons = 0;
        apb = '0;
        start = 1'b0;
        ce = 1'b1;
        srst = 1'b1;
        void'($urandom(48229));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rdc(lhr_pkg::LHR_SEL_ADDR, 32'h3);
        rdc(lhr_pkg::LHR_MASK_ADDR, 32'h0);
        rdc(lhr_pkg::LHR_STATE_ADDR, 32'h0);
        bus(1'b0, 12'h020, 32'h0);
        chk({31'h0, serr}, 32'h1);
        // Clock enable low must freeze the registers
        ce <= 1'b0;
        wr(lhr_pkg::LHR_SHA_ADDR, 32'h5a);
        ce <= 1'b1;
        rdc(lhr_pkg::LHR_SHA_ADDR, 32'h0);
        wr(lhr_pkg::LHR_CTRL_ADDR, 32'h1);
        for (int c = 0; c < 7; c++)
        begin
            k = $urandom_range(3, 1);
            wr(lhr_pkg::LHR_SEL_ADDR, 32'(c));
            rdc(lhr_pkg::LHR_SEL_ADDR, 32'(c));
            p = iv_q[c] * k;
            lhr_enc_model_i.drive(p - 32'h3, 1'b0, 1);
            go();
            lhr_enc_model_i.drive(p - 32'h3, 1'b1, 2);
            lhr_enc_model_i.drive(p - 32'h3, 1'b0, 2);
            lhr_enc_model_i.drive(p + 32'h2, 1'b0, 0);
            run(p, 2);
        end
        wr(lhr_pkg::LHR_SEL_ADDR, 32'h7);
        rdc(lhr_pkg::LHR_SEL_ADDR, 32'h6);
        rdc(lhr_pkg::LHR_STS_ADDR, 32'hd);
        irq_is(1'b0);
        wr(lhr_pkg::LHR_MASK_ADDR, 32'h8);
        irq_is(1'b1);
        wr(lhr_pkg::LHR_STS_ADDR, 32'h8);
        irq_is(1'b0);
        wr(lhr_pkg::LHR_STS_ADDR, 32'hf);
        wr(lhr_pkg::LHR_MASK_ADDR, 32'h2);
        p = $urandom;
        lhr_enc_model_i.drive(p, 1'b0, 1);
        wr(lhr_pkg::LHR_CTRL_ADDR, 32'hb);
        run(p, 1);
        rdc(lhr_pkg::LHR_HOME_ADDR, p);
        wr(lhr_pkg::LHR_CTRL_ADDR, 32'ha);
        irq_is(1'b1);
        wr(lhr_pkg::LHR_STS_ADDR, 32'h2);
        irq_is(1'b0);
        sh = $urandom;
        wr(lhr_pkg::LHR_SHA_ADDR, sh);
        p = $urandom;
        wr(lhr_pkg::LHR_SHB_ADDR, p);
        sh = sh + p;
        wr(lhr_pkg::LHR_SEL_ADDR, 32'h0);
        wr(lhr_pkg::LHR_CTRL_ADDR, 32'h0);
        m = $urandom & 32'h0fffffff;
        inc_ret(m, 1'b1);
        inc_ret(m + 32'h100, 1'b0);
        irq_is(1'b1);
        wr(lhr_pkg::LHR_STS_ADDR, 32'hf);
        wr(lhr_pkg::LHR_CTRL_ADDR, 32'h4);
        inc_ret(m + 32'h300, 1'b1);
        lhr_enc_model_i.drive(m, 1'b0, 1);
        go();
        lhr_enc_model_i.drive(m, 1'b1, 2);
        lhr_enc_model_i.drive(m + 32'h40, 1'b0, 2);
        run(32'h0, 0);
        test_done();
    end
endmodule
